// ---- rtl/pwm_timer_pkg.sv ----
// package: register map, bit positions and mode codes of the pwm timer
// assumes an 8-bit register port with one-cycle read latency
package pwm_timer_pkg;
   // register offsets (word index on the register port)
   localparam logic [4:0] clock_gate_addr    = 5'h00;
   localparam logic [4:0] count_start_addr   = 5'h01;
   localparam logic [4:0] irq_mask_addr      = 5'h02;
   localparam logic [4:0] irq_request_addr   = 5'h03;
   localparam logic [4:0] priority_lo_addr   = 5'h04;
   localparam logic [4:0] priority_hi_addr   = 5'h05;
   localparam logic [4:0] mode_select_addr   = 5'h06;
   localparam logic [4:0] function_ctrl_addr = 5'h07;
   localparam logic [4:0] cutoff_u0_addr     = 5'h08;
   localparam logic [4:0] cutoff_u1_addr     = 5'h09;
   localparam logic [4:0] period_addr        = 5'h0A;
   localparam logic [4:0] change1_addr       = 5'h0C;
   localparam logic [4:0] change2_addr       = 5'h0E;
   localparam logic [4:0] change3_addr       = 5'h10;
   localparam logic [4:0] period_buf_addr    = 5'h12;
   localparam logic [4:0] change1_buf_addr   = 5'h14;
   localparam logic [4:0] change2_buf_addr   = 5'h16;
   localparam logic [4:0] change3_buf_addr   = 5'h18;
   localparam logic [4:0] counter_addr       = 5'h1A;
   localparam logic [4:0] cutoff_in_addr     = 5'h1C;
   localparam logic [4:0] gen_reg_count      = 5'h09;
   // bit positions
   localparam int gate_bit       = 4;
   localparam int continue_bit   = 2;
   localparam int run_bit        = 0;
   localparam int irq_bit        = 1;
   localparam int buf_d_u1_bit   = 7;
   localparam int buf_c_u1_bit   = 6;
   localparam int buf_d_u0_bit   = 5;
   localparam int buf_c_u0_bit   = 4;
   localparam int sync_bit       = 0;
   localparam int counter_pol_bit = 3;
   localparam int normal_pol_bit = 2;
   localparam int mode_hi_bit    = 1;
   localparam int mode_lo_bit    = 0;
   // combination mode codes
   localparam logic [1:0] mode_timer     = 2'h0;
   localparam logic [1:0] mode_reset_pwm = 2'h1;
   // cutoff field codes
   localparam logic [1:0] cutoff_off   = 2'h0;
   localparam logic [1:0] cutoff_hiz   = 2'h1;
   localparam logic [1:0] cutoff_low   = 2'h2;
   localparam logic [1:0] cutoff_high  = 2'h3;
   localparam logic [7:0] zero_byte    = 8'h00;
   localparam logic [15:0] zero_word   = 16'h0000;
   localparam logic [15:0] one_word    = 16'h0001;
endpackage

// ---- rtl/pwm_cutoff_pin.sv ----
// one pwm pin: polarity, cutoff override and output enable
// assumes raw_active is the pin's active-phase request
`timescale 1ns/10ps
module pwm_cutoff_pin
(
   // pin behaviour
   input  wire logic       raw_active,
   input  wire logic       polarity,
   input  wire logic       pwm_mode,
   input  wire logic       cut,
   input  wire logic [1:0] cutoff_sel,
   // pin drive
   output logic            pin_out,
   output logic            pin_oe
);
   wire logic level_pwm;
   wire logic cut_on;

   // polarity 0: high idle, low active; 1: inverse
   assign level_pwm = polarity ? raw_active : ~raw_active;
   // timer mode ignores polarity; reset-pwm and complementary modes use it
   wire logic level;
   assign level  = pwm_mode ? level_pwm : raw_active;
   assign cut_on = cut && (cutoff_sel != pwm_timer_pkg::cutoff_off);
   assign pin_out = cut_on ? (cutoff_sel == pwm_timer_pkg::cutoff_high)
                           : level;
   assign pin_oe  = ~(cut_on && (cutoff_sel == pwm_timer_pkg::cutoff_hiz));
endmodule // pwm_cutoff_pin

// ---- rtl/pwm_phase_compare.sv ----
// compare of one change point against the unit 0 count
// assumes count restarts at zero each period
`timescale 1ns/10ps
module pwm_phase_compare
#(
   parameter int width = 16
)
(
   // count and threshold
   input  wire logic [width-1:0] count,
   input  wire logic [width-1:0] change_point,
   // phase request
   output logic                  active
);
   // inactive for change_point+1 counts, then active
   assign active = count > change_point;
endmodule // pwm_phase_compare

// ---- rtl/pwm_timer_ctrl.sv ----
// two-unit pwm timer control: registers, unit 0 count, six pwm pins
// assumes software keeps field codes legal and counts with sys_clk
// Overview of operation
// - gate bit zero resets timer, blocks writes
// - continue bit selects stop or run after match
// - run flag starts and stops unit 0
// - mask bit one blocks timer interrupt
// - request flag pending, software writes zero clears
// - two priority bits select level zero to three
// - unit 1 buffer selects for general registers
// - unit 0 buffer selects for period, change point
// - sync bit: independent or synchronous counters
// - counter-phase polarity select
// - normal-phase polarity select
// - polarity ignored in timer mode only
// - combination field selects operating mode
// - complementary transfer at underflow or match
// - cutoff codes: off, hiz, low, high
// - two two-bit cutoff fields for unit 0, four for unit 1
// - counter clears on period match
// - normal-phase outputs inactive change point plus one
`timescale 1ns/10ps
module pwm_timer_ctrl
#(
   parameter int width = 16
)
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // register port
   input  wire logic [4:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_write,
   input  wire logic             reg_read,
   output logic      [7:0]       reg_rdata,
   // forced cutoff request
   input  wire logic             cutoff_request,
   // pwm pins, order: b0 d0 a1 c1 b1 d1
   output logic      [5:0]       pwm_out,
   output logic      [5:0]       pwm_oe,
   // interrupt towards the cpu
   output logic                  unit0_timer_interrupt,
   output logic      [1:0]       timer_irq_priority
);
   typedef enum logic [1:0] {idle_type_s, run_s, held_s} run_state_type;

   run_state_type     state;
   run_state_type     next_state;
   logic [7:0]        peripheral_clock_gate;
   logic [7:0]        count_start_control;
   logic [7:0]        interrupt_mask_high;
   logic [7:0]        interrupt_request_high;
   logic [7:0]        priority_low_bit_reg;
   logic [7:0]        priority_high_bit_reg;
   logic [7:0]        timer_mode_select;
   logic [7:0]        function_control;
   logic [7:0]        cutoff_select_unit0;
   logic [7:0]        cutoff_select_unit1;
   logic [width-1:0]  gen_reg [0:8];
   logic [width-1:0]  unit1_counter;
   logic              unit1_underflow_q;
   logic [7:0]        next_rdata;

   wire logic         gate_on;
   wire logic         wr;
   wire logic         count_run;
   wire logic         period_match;
   wire logic         pwm_mode;
   wire logic         comp_mode;
   wire logic         transfer;
   wire logic         irq_set;
   wire logic         req_clear;
   wire logic         cutoff_wr_ok;
   wire logic [1:0]   mode_field;
   wire logic [5:0]   raw;
   wire logic [5:0]   pol;
   wire logic [11:0]  sel;
   wire logic [4:0]   wide_idx;
   wire logic         wide_hit;
   wire logic [3:0]   idx;

   // word index and half of the 16-bit registers
   function automatic logic [3:0] word_index(input logic [4:0] a);
      logic [4:0] off;
      off = a - pwm_timer_pkg::period_addr;
      return off[4:1];
   endfunction

   function automatic logic [7:0] half(input logic [width-1:0] v,
                                       input logic hi);
      return hi ? v[15:8] : v[7:0];
   endfunction

   assign gate_on    = peripheral_clock_gate[pwm_timer_pkg::gate_bit];
   assign wr         = reg_write && gate_on;
   assign count_run  = (state == run_s);
   assign mode_field = function_control[pwm_timer_pkg::mode_hi_bit:
                                        pwm_timer_pkg::mode_lo_bit];
   assign pwm_mode   = (mode_field == pwm_timer_pkg::mode_reset_pwm)
                       || mode_field[pwm_timer_pkg::mode_hi_bit];
   assign comp_mode  = mode_field[pwm_timer_pkg::mode_hi_bit];
   assign period_match = count_run && (gen_reg[0] == gen_reg[8]);
   // complementary transfer: underflow of unit 1 or period match
   assign transfer   = comp_mode ?
                       (mode_field[pwm_timer_pkg::mode_lo_bit] ?
                        period_match : unit1_underflow_q)
                       : period_match;
   assign irq_set    = period_match;
   assign req_clear  = wr && (reg_addr == pwm_timer_pkg::irq_request_addr)
                       && !reg_wdata[pwm_timer_pkg::irq_bit];
   assign cutoff_wr_ok = wr && !count_run;
   assign wide_idx   = reg_addr - pwm_timer_pkg::period_addr;
   assign wide_hit   = (reg_addr >= pwm_timer_pkg::period_addr)
                       && (reg_addr < pwm_timer_pkg::counter_addr);
   assign idx        = word_index(reg_addr);

   // state of the unit 0 count
   always_comb
   begin
      next_state = state;
      unique case (state)
         idle_type_s:
            if (count_start_control[pwm_timer_pkg::run_bit])
               next_state = run_s;
         run_s:
            if (!count_start_control[pwm_timer_pkg::run_bit])
               next_state = idle_type_s;
            else if (period_match &&
                     !count_start_control[pwm_timer_pkg::continue_bit])
               next_state = held_s;
         held_s:
            if (!count_start_control[pwm_timer_pkg::run_bit])
               next_state = idle_type_s;
         default:
            next_state = idle_type_s;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         peripheral_clock_gate <= pwm_timer_pkg::zero_byte;
      else if (reg_write && reg_addr == pwm_timer_pkg::clock_gate_addr)
         peripheral_clock_gate <= reg_wdata;
   end

   // all timer state held in reset while the gate is off
   always_ff @(posedge sys_clk)
   begin
      if (rst || !gate_on)
      begin
         state                  <= idle_type_s;
         count_start_control    <= pwm_timer_pkg::zero_byte;
         timer_mode_select      <= pwm_timer_pkg::zero_byte;
         function_control       <= pwm_timer_pkg::zero_byte;
         cutoff_select_unit0    <= pwm_timer_pkg::zero_byte;
         cutoff_select_unit1    <= pwm_timer_pkg::zero_byte;
         interrupt_mask_high    <= 8'hFF;
         priority_low_bit_reg   <= 8'hFF;
         priority_high_bit_reg  <= 8'hFF;
      end
      else
      begin
         state <= next_state;
         if (wr && reg_addr == pwm_timer_pkg::count_start_addr)
            count_start_control <= reg_wdata;
         else if (next_state == held_s)
            count_start_control[pwm_timer_pkg::run_bit] <= 1'b0;
         if (wr && reg_addr == pwm_timer_pkg::mode_select_addr)
            timer_mode_select <= reg_wdata;
         if (wr && reg_addr == pwm_timer_pkg::function_ctrl_addr)
            function_control <= reg_wdata;
         if (cutoff_wr_ok && reg_addr == pwm_timer_pkg::cutoff_u0_addr)
            cutoff_select_unit0 <= reg_wdata;
         if (cutoff_wr_ok && reg_addr == pwm_timer_pkg::cutoff_u1_addr)
            cutoff_select_unit1 <= reg_wdata;
         if (wr && reg_addr == pwm_timer_pkg::irq_mask_addr)
            interrupt_mask_high <= reg_wdata;
         if (wr && reg_addr == pwm_timer_pkg::priority_lo_addr)
            priority_low_bit_reg <= reg_wdata;
         if (wr && reg_addr == pwm_timer_pkg::priority_hi_addr)
            priority_high_bit_reg <= reg_wdata;
      end
   end

   // request flag: a new match wins over a clear
   always_ff @(posedge sys_clk)
   begin
      if (rst || !gate_on)
         interrupt_request_high <= pwm_timer_pkg::zero_byte;
      else if (irq_set)
         interrupt_request_high[pwm_timer_pkg::irq_bit] <= 1'b1;
      else if (req_clear)
         interrupt_request_high[pwm_timer_pkg::irq_bit] <= 1'b0;
   end

   // general registers, buffers and unit 0 count (index 8)
   always_ff @(posedge sys_clk)
   begin
      if (rst || !gate_on)
      begin
         for (int i = 0; i < 9; i++)
            gen_reg[i] <= pwm_timer_pkg::zero_word;
      end
      else
      begin
         if (wr && wide_hit)
         begin
            if (wide_idx[0])
               gen_reg[idx][15:8] <= reg_wdata;
            else
               gen_reg[idx][7:0] <= reg_wdata;
         end
         if (period_match)
            gen_reg[8] <= pwm_timer_pkg::zero_word;
         else if (count_run)
            gen_reg[8] <= gen_reg[8] + pwm_timer_pkg::one_word;
         if (transfer)
         begin
            if (timer_mode_select[pwm_timer_pkg::buf_c_u0_bit])
               gen_reg[0] <= gen_reg[4];
            if (timer_mode_select[pwm_timer_pkg::buf_d_u0_bit])
               gen_reg[1] <= gen_reg[5];
            if (timer_mode_select[pwm_timer_pkg::buf_c_u1_bit])
               gen_reg[2] <= gen_reg[6];
            if (timer_mode_select[pwm_timer_pkg::buf_d_u1_bit])
               gen_reg[3] <= gen_reg[7];
         end
      end
   end

   // unit 1 counts down only in complementary mode
   always_ff @(posedge sys_clk)
   begin
      if (rst || !gate_on)
      begin
         unit1_counter     <= pwm_timer_pkg::zero_word;
         unit1_underflow_q <= 1'b0;
      end
      else
      begin
         unit1_underflow_q <= 1'b0;
         if (count_run && comp_mode)
         begin
            if (unit1_counter == pwm_timer_pkg::zero_word)
            begin
               unit1_counter     <= gen_reg[0];
               unit1_underflow_q <= 1'b1;
            end
            else
               unit1_counter <= unit1_counter - pwm_timer_pkg::one_word;
         end
         else if (timer_mode_select[pwm_timer_pkg::sync_bit])
            unit1_counter <= gen_reg[8];
      end
   end

   // register read mux
   always_comb
   begin
      next_rdata = pwm_timer_pkg::zero_byte;
      if (reg_addr == pwm_timer_pkg::clock_gate_addr)
         next_rdata = peripheral_clock_gate;
      else if (!gate_on)
         next_rdata = pwm_timer_pkg::zero_byte;
      else if (wide_hit)
         next_rdata = half(gen_reg[idx], wide_idx[0]);
      else if (reg_addr == pwm_timer_pkg::counter_addr)
         next_rdata = gen_reg[8][7:0];
      else if (reg_addr == pwm_timer_pkg::counter_addr + 5'h01)
         next_rdata = gen_reg[8][15:8];
      else
         unique case (reg_addr)
            pwm_timer_pkg::count_start_addr:
               next_rdata = count_start_control;
            pwm_timer_pkg::irq_mask_addr:
               next_rdata = interrupt_mask_high;
            pwm_timer_pkg::irq_request_addr:
               next_rdata = interrupt_request_high;
            pwm_timer_pkg::priority_lo_addr:
               next_rdata = priority_low_bit_reg;
            pwm_timer_pkg::priority_hi_addr:
               next_rdata = priority_high_bit_reg;
            pwm_timer_pkg::mode_select_addr:
               next_rdata = timer_mode_select;
            pwm_timer_pkg::function_ctrl_addr:
               next_rdata = function_control;
            pwm_timer_pkg::cutoff_u0_addr:
               next_rdata = cutoff_select_unit0;
            pwm_timer_pkg::cutoff_u1_addr:
               next_rdata = cutoff_select_unit1;
            default:
               next_rdata = pwm_timer_pkg::zero_byte;
         endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         reg_rdata <= pwm_timer_pkg::zero_byte;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= pwm_timer_pkg::zero_byte;
   end

   assign unit0_timer_interrupt =
      interrupt_request_high[pwm_timer_pkg::irq_bit]
      && !interrupt_mask_high[pwm_timer_pkg::irq_bit];
   assign timer_irq_priority =
      {priority_high_bit_reg[pwm_timer_pkg::irq_bit],
       priority_low_bit_reg[pwm_timer_pkg::irq_bit]};

   // cutoff fields: b0, d0 from unit 0; a1, c1, b1, d1 from unit 1
   assign sel = {cutoff_select_unit0[5:4], cutoff_select_unit0[1:0],
                 cutoff_select_unit1[7:6], cutoff_select_unit1[3:2],
                 cutoff_select_unit1[5:4], cutoff_select_unit1[1:0]};
   assign pol = {function_control[pwm_timer_pkg::normal_pol_bit],
                 function_control[pwm_timer_pkg::counter_pol_bit],
                 function_control[pwm_timer_pkg::normal_pol_bit],
                 function_control[pwm_timer_pkg::counter_pol_bit],
                 function_control[pwm_timer_pkg::normal_pol_bit],
                 function_control[pwm_timer_pkg::counter_pol_bit]};

   pwm_phase_compare #(.width(width)) u_cmp1
   (
      .count        (gen_reg[8]),
      .change_point (gen_reg[1]),
      .active       (raw[5])
   );
   pwm_phase_compare #(.width(width)) u_cmp2
   (
      .count        (gen_reg[8]),
      .change_point (gen_reg[2]),
      .active       (raw[3])
   );
   pwm_phase_compare #(.width(width)) u_cmp3
   (
      .count        (gen_reg[8]),
      .change_point (gen_reg[3]),
      .active       (raw[1])
   );
   // counter phase is the inverse of its normal phase
   assign raw[4] = ~raw[5];
   assign raw[2] = ~raw[3];
   assign raw[0] = ~raw[1];

   for (genvar p = 0; p < 6; p++)
   begin : g_pin
      pwm_cutoff_pin u_pin
      (
         .raw_active (raw[p] && count_run),
         .polarity   (pol[p]),
         .pwm_mode   (pwm_mode),
         .cut        (cutoff_request),
         .cutoff_sel (sel[2*p+1:2*p]),
         .pin_out    (pwm_out[p]),
         .pin_oe     (pwm_oe[p])
      );
   end
endmodule // pwm_timer_ctrl

// ---- tb/switch_stage_model.sv ----
// partner: six switching stages sensing the pwm pins
// assumes a weak pull-down on each stage input while a pin floats
`timescale 1ns/10ps
module switch_stage_model
(
   // pin drive from the timer
   input  wire logic [5:0] pin_level,
   input  wire logic [5:0] pin_drive,
   // level seen by each stage
   output logic      [5:0] sensed
);
   // released pin falls to the pull-down level, never the last value
   assign sensed = pin_level & pin_drive;
endmodule // switch_stage_model

// ---- tb/pwm_timer_ctrl_asserts.sv ----
// checker: register port, interrupt and pin relations of the timer
// assumes binding onto pwm_timer_ctrl, one sys_clk domain
`timescale 1ns/10ps
module pwm_timer_ctrl_asserts
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // pins and interrupt
   input wire logic       cutoff_request,
   input wire logic [5:0] pwm_oe,
   input wire logic       unit0_timer_interrupt,
   input wire logic [1:0] timer_irq_priority
);
   logic gate_q;
   logic mask_q;
   logic pr_lo_q;
   logic pr_hi_q;
   wire  wr_on = reg_write && gate_q;
   wire  next_mask = (wr_on && reg_addr == pwm_timer_pkg::irq_mask_addr)
                     ? reg_wdata[1] : mask_q;
   wire  next_pr_lo = (wr_on && reg_addr == pwm_timer_pkg::priority_lo_addr)
                      ? reg_wdata[1] : pr_lo_q;
   wire  next_pr_hi = (wr_on && reg_addr == pwm_timer_pkg::priority_hi_addr)
                      ? reg_wdata[1] : pr_hi_q;
   wire  gate_wr = reg_write && reg_addr == pwm_timer_pkg::clock_gate_addr;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         gate_q <= 1'b0;
      else if (gate_wr)
         gate_q <= reg_wdata[pwm_timer_pkg::gate_bit];
   end

   // shadows of mask and priority bits, held at reset while gated
   always_ff @(posedge sys_clk)
   begin
      if (rst || !gate_q)
         {mask_q, pr_lo_q, pr_hi_q} <= 3'h7;
      else
         {mask_q, pr_lo_q, pr_hi_q} <= {next_mask, next_pr_lo, next_pr_hi};
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   read_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   gate_refuse_a: assert property (
      reg_read && !gate_q && reg_addr != 5'h00 |=> reg_rdata == 8'h00)
      else $error("register readable while clock gated");
   gate_read_a: assert property (
      reg_read && reg_addr == pwm_timer_pkg::clock_gate_addr
      |=> reg_rdata[4] == $past(gate_q))
      else $error("gate bit read back wrong");
   mask_blocks_a: assert property (mask_q |-> !unit0_timer_interrupt)
      else $error("interrupt raised while masked");
   priority_map_a: assert property (
      timer_irq_priority == {pr_hi_q, pr_lo_q})
      else $error("priority level does not follow its bits");
   irq_hold_a: assert property (
      unit0_timer_interrupt && !reg_write |=> unit0_timer_interrupt)
      else $error("pending request vanished without a write");
   pins_driven_a: assert property (!cutoff_request |-> pwm_oe == 6'h3F)
      else $error("pin released without cutoff request");
   unmapped_zero_a: assert property (
      reg_read && reg_addr >= 5'h1E |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // pwm_timer_ctrl_asserts

bind pwm_timer_ctrl pwm_timer_ctrl_asserts chk_u (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .cutoff_request(cutoff_request),
   .pwm_oe(pwm_oe), .unit0_timer_interrupt(unit0_timer_interrupt),
   .timer_irq_priority(timer_irq_priority));

// ---- tb/pwm_timer_ctrl_bench.sv ----
// bench: register sequences, pwm waveform, cutoff and gate checks
// assumes period 7 and change points 2, 4, 5 on sys_clk counting
`timescale 1ns/10ps
module pwm_timer_ctrl_bench;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic       cutoff_request = 1'b0;
   logic [7:0] reg_rdata;
   logic [5:0] pwm_out;
   logic [5:0] pwm_oe;
   logic [5:0] sensed;
   logic       irq;
   logic [1:0] prio;
   int         miscompares = 0;
   int         comparisons = 0;
   logic [4:0] tab_addr [8] = '{5'h0A, 5'h0C, 5'h0E, 5'h10,
                                5'h12, 5'h14, 5'h16, 5'h18};
   logic [7:0] tab_data [8] = '{8'h07, 8'h02, 8'h04, 8'h05,
                                8'h07, 8'h02, 8'h04, 8'h05};

   always #2 sys_clk = ~sys_clk;

   pwm_timer_ctrl dut_u (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .cutoff_request(cutoff_request),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .unit0_timer_interrupt(irq), .timer_irq_priority(prio));

   switch_stage_model stage_u (
      .pin_level(pwm_out), .pin_drive(pwm_oe), .sensed(sensed));

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      check("read data", reg_rdata, exp);
   endtask

   // pins b0 d0 a1 c1 b1 d1 at count c
   function automatic logic [5:0] exp_pins(input int c, input logic pn,
                                           input logic pc);
      logic [2:0] act;
      act = {c > 2, c > 4, c > 5};
      return {act[2] ^ ~pn, act[2] ^ pc, act[1] ^ ~pn, act[1] ^ pc,
              act[0] ^ ~pn, act[0] ^ pc};
   endfunction

   task automatic run_period(input logic pn, input logic pc);
      int k;
      logic [5:0] ep;
      wr(pwm_timer_pkg::function_ctrl_addr, {4'h0, pc, pn, 2'h1});
      wr(pwm_timer_pkg::irq_request_addr, 8'h00);
      // let the clear settle before polling the request
      #1;
      k = 0;
      while (irq !== 1'b1 && k < 40)
      begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("interrupt", {7'h00, irq}, 8'h01);
      wr(pwm_timer_pkg::irq_request_addr, 8'h00);
      for (k = 2; k < 10; k++)
      begin
         #1;
         ep = exp_pins(k % 8, pn, pc);
         check("pins", {2'h0, pwm_out}, {2'h0, ep});
         check("interrupt", {7'h00, irq}, {7'h00, k > 7});
         @(posedge sys_clk);
      end
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #80000;
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      check("priority", {6'h00, prio}, 8'h03);
      wr(pwm_timer_pkg::irq_mask_addr, 8'h00);
      rd(pwm_timer_pkg::irq_mask_addr, 8'h00);
      wr(pwm_timer_pkg::clock_gate_addr, 8'h10);
      rd(pwm_timer_pkg::clock_gate_addr, 8'h10);
      rd(pwm_timer_pkg::irq_mask_addr, 8'hFF);
      rd(5'h1F, 8'h00);
      for (int l = 0; l < 4; l++)
      begin
         wr(pwm_timer_pkg::priority_hi_addr, {6'h00, l[1], 1'b0});
         wr(pwm_timer_pkg::priority_lo_addr, {6'h00, l[0], 1'b0});
         #1;
         check("priority", {6'h00, prio}, l[7:0]);
      end
      wr(pwm_timer_pkg::mode_select_addr, 8'hF0);
      rd(pwm_timer_pkg::mode_select_addr, 8'hF0);
      for (int i = 0; i < 8; i++)
         wr(tab_addr[i], tab_data[i]);
      rd(pwm_timer_pkg::change2_buf_addr, 8'h04);
      wr(pwm_timer_pkg::irq_mask_addr, 8'h00);
      wr(pwm_timer_pkg::count_start_addr, 8'h05);
      rd(pwm_timer_pkg::count_start_addr, 8'h05);
      run_period(1'b0, 1'b0);
      run_period(1'b1, 1'b0);
      run_period(1'b0, 1'b1);
      wr(pwm_timer_pkg::cutoff_u0_addr, 8'h23);
      rd(pwm_timer_pkg::cutoff_u0_addr, 8'h00);
      wr(pwm_timer_pkg::irq_mask_addr, 8'h02);
      #1;
      check("interrupt", {7'h00, irq}, 8'h00);
      wr(pwm_timer_pkg::count_start_addr, 8'h04);
      rd(pwm_timer_pkg::count_start_addr, 8'h04);
      wr(pwm_timer_pkg::function_ctrl_addr, 8'h00);
      #1;
      check("pins", {2'h0, pwm_out}, 8'h00);
      wr(pwm_timer_pkg::function_ctrl_addr, 8'h01);
      #1;
      check("pins", {2'h0, pwm_out}, 8'h3F);
      wr(pwm_timer_pkg::cutoff_u0_addr, 8'h23);
      wr(pwm_timer_pkg::cutoff_u1_addr, 8'h6C);
      rd(pwm_timer_pkg::cutoff_u0_addr, 8'h23);
      rd(pwm_timer_pkg::cutoff_u1_addr, 8'h6C);
      @(posedge sys_clk);
      cutoff_request <= 1'b1;
      @(posedge sys_clk);
      #1;
      check("pin drive", {2'h0, pwm_oe}, 8'h37);
      check("sensed", {2'h0, sensed}, 8'h15);
      @(posedge sys_clk);
      cutoff_request <= 1'b0;
      wr(pwm_timer_pkg::cutoff_u0_addr, 8'h00);
      wr(pwm_timer_pkg::cutoff_u1_addr, 8'h00);
      wr(pwm_timer_pkg::irq_request_addr, 8'h00);
      wr(pwm_timer_pkg::change1_buf_addr, 8'h03);
      wr(pwm_timer_pkg::count_start_addr, 8'h01);
      repeat (20) @(posedge sys_clk);
      rd(pwm_timer_pkg::count_start_addr, 8'h00);
      rd(pwm_timer_pkg::change1_addr, 8'h03);
      // complementary, lower bit 0: transfer on unit 1 underflow only
      wr(pwm_timer_pkg::function_ctrl_addr, 8'h02);
      wr(pwm_timer_pkg::change2_buf_addr, 8'h06);
      wr(pwm_timer_pkg::count_start_addr, 8'h05);
      rd(pwm_timer_pkg::count_start_addr, 8'h05);
      wr(pwm_timer_pkg::count_start_addr, 8'h04);
      rd(pwm_timer_pkg::change2_addr, 8'h06);
      wr(pwm_timer_pkg::clock_gate_addr, 8'h00);
      rd(pwm_timer_pkg::mode_select_addr, 8'h00);
      wr(pwm_timer_pkg::clock_gate_addr, 8'h10);
      rd(pwm_timer_pkg::mode_select_addr, 8'h00);
      rd(pwm_timer_pkg::irq_mask_addr, 8'hFF);
      report_and_stop();
   end
endmodule // pwm_timer_ctrl_bench
